// [common/fep_pkg.sv]
package fep_pkg;

  // register byte offsets
  localparam logic [7:0] OFF_PROT     = 8'h00;
  localparam logic [7:0] OFF_STAT     = 8'h04;
  localparam logic [7:0] OFF_CMD      = 8'h08;
  localparam logic [7:0] OFF_ADDR     = 8'h0C;
  localparam logic [7:0] OFF_DATA     = 8'h10;
  localparam logic [7:0] OFF_CDIV     = 8'h14;
  localparam logic [7:0] OFF_SEC      = 8'h18;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h1C;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h20;

  // status register bit positions
  localparam int STAT_CBEF   = 7;
  localparam int STAT_CCF    = 6;
  localparam int STAT_PVIOL  = 5;
  localparam int STAT_ACCERR = 4;
  localparam int STAT_BLANK  = 2;

  // protection register fields
  localparam int EPS_HI = 7;
  localparam int EPS_LO = 6;
  localparam int FPS_HI = 5;
  localparam int FPS_LO = 0;

  localparam logic [1:0]  EPS_NONE      = 2'h3;
  localparam logic [5:0]  FPS_NONE      = 6'h3F;
  localparam logic [5:0]  FPS_ALL       = 6'h18;
  localparam logic [15:0] EE_PROT_END   = 16'h17FF;
  localparam logic [15:0] EE_PROT_LIMIT = 16'h1800;
  localparam logic [15:0] EE_PROT_UNIT  = 16'h0010;
  localparam logic [16:0] FL_TOP        = 17'h10000;
  localparam logic [16:0] FL_PAIR_SIZE  = 17'h00600;
  localparam logic [15:0] EE_REGION_END = 16'h17FF;

  // command codes
  localparam logic [7:0] CMD_BLANK  = 8'h05;
  localparam logic [7:0] CMD_BYTE   = 8'h20;
  localparam logic [7:0] CMD_BURST  = 8'h25;
  localparam logic [7:0] CMD_SECT   = 8'h40;
  localparam logic [7:0] CMD_MASS   = 8'h41;
  localparam logic [7:0] CMD_ABORT  = 8'h47;

  // security codes
  localparam logic [1:0] SEC_UNSECURED = 2'h2;
  localparam logic [1:0] SEC_RESET     = 2'h3;

  // interrupt status bits
  localparam int IRQ_W      = 3;
  localparam int IRQ_DONE   = 0;
  localparam int IRQ_PVIOL  = 1;
  localparam int IRQ_ACCERR = 2;

  // reset values
  localparam logic [7:0] PROT_RESET = 8'hFF;
  localparam logic [7:0] CDIV_RESET = 8'h00;

  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : fep_pkg

// [logic/fep_ctrl.sv]
`timescale 1ns/10ps
// Function
// [RULE1] after reset, protection register is loaded from the stored protection byte
// [RULE2] protection always readable; writes only accepted when protected area does not shrink
// [RULE3] program or erase aimed at protected location is ignored and sets violation flag
// [RULE4] mass erase refused while any flash or eeprom sector is protected
// [RULE5] eeprom field 7:6: 3 none, 2 from 17F0, 1 from 17E0, 0 from 17C0
// [RULE6] flash field 5:0: 3F none, each step down adds 1.5K, 18..00 protect all
// [RULE7] writing one to buffer-empty bit 7 launches; flag clears, burst hand-off refills it
// [RULE8] only burst program is buffered; empty flag one means another burst may follow
// [RULE9] complete flag bit 6 set when idle and empty, cleared on launch, read only
// [RULE10] violation flag bit 5 cleared only by writing one
// [RULE11] access error bit 4 on bad sequence, divider unset, or stop during command
// [RULE12] access error flag cleared by writing one, zero has no effect
// [RULE13] blank flag bit 2 set when blank check finds all erased; cleared on launch
// [RULE14] six codes accepted: 05, 20, 25, 40, 41, 47
// [RULE15] any other command code raises access error
// [RULE16] debug port may rewrite protection register bits freely
// [RULE17] successful flash blank check sets security code to unsecured 1:0
// [RULE18] status bits 3, 1, 0 read zero and ignore writes
module fep_ctrl #(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // axi4-lite write address
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]        s_axi_awprot,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // axi4-lite write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // axi4-lite read address
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]        s_axi_arprot,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  // axi4-lite read data
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // nonvolatile copies taken after reset
  input  wire logic [7:0]        stored_protection_byte,
  input  wire logic [1:0]        stored_security_code,
  // background debug access to protection
  input  wire logic              debug_prot_we,
  input  wire logic [7:0]        debug_prot_data,
  // system state
  input  wire logic              stop_mode,
  // array sequencer
  output logic                   arr_start,
  output logic                   arr_abort,
  output logic [7:0]             arr_cmd,
  output logic [15:0]            arr_addr,
  output logic [7:0]             arr_data,
  input  wire logic              arr_done,
  input  wire logic              arr_blank_ok,
  // status out
  output logic [1:0]             security_state_code,
  output logic                   irq
);

  ////////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic ee_hit(input logic [15:0] a, input logic [1:0] eeprom_protect_select);
    logic [15:0] base;
    base = fep_pkg::EE_PROT_LIMIT - (fep_pkg::EE_PROT_UNIT << (2'd2 - eeprom_protect_select));
    ee_hit = (eeprom_protect_select != fep_pkg::EPS_NONE) && (a >= base) && (a <= fep_pkg::EE_PROT_END);  // see [RULE5]
  endfunction : ee_hit

  function automatic logic fl_hit(input logic [15:0] a, input logic [5:0] flash_protect_select);
    logic [16:0] base;
    logic [16:0] steps;
    steps = {11'h000, fep_pkg::FPS_NONE - flash_protect_select};
    base  = fep_pkg::FL_TOP - 17'(steps * fep_pkg::FL_PAIR_SIZE);
    if (flash_protect_select == fep_pkg::FPS_NONE)
      fl_hit = 1'b0;
    else if (flash_protect_select <= fep_pkg::FPS_ALL)
      fl_hit = 1'b1;
    else
      fl_hit = ({1'b0, a} >= base);  // see [RULE6]
  endfunction : fl_hit

  function automatic logic [5:0] fps_eff(input logic [5:0] flash_protect_select);
    fps_eff = (flash_protect_select < fep_pkg::FPS_ALL) ? fep_pkg::FPS_ALL : flash_protect_select;
  endfunction : fps_eff

  function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) r[i*8 +: 8] = nw[i*8 +: 8];
    end
    lane_merge = r;
  endfunction : lane_merge

  ////////////////////////////////////////////////////////////////////////////////
  // axi4-lite slave

  logic              aw_have_q, aw_have_d;
  logic              w_have_q, w_have_d;
  logic [ADDR_W-1:0] awaddr_q, awaddr_d;
  logic [31:0]       wdata_q, wdata_d;
  logic [3:0]        wstrb_q, wstrb_d;
  logic              bvalid_q, bvalid_d;
  logic [1:0]        bresp_q, bresp_d;
  logic              rvalid_q, rvalid_d;
  logic [1:0]        rresp_q, rresp_d;
  logic [31:0]       rdata_q, rdata_d;

  logic              wr_fire;
  logic [7:0]        wr_addr;
  logic [31:0]       wr_data;
  logic [3:0]        wr_strb;
  logic              wr_known;
  logic [31:0]       rd_val;
  logic              rd_known;

  assign s_axi_awready = !aw_have_q && !bvalid_q;
  assign s_axi_wready  = !w_have_q && !bvalid_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rdata   = rdata_q;

  always_comb begin
    aw_have_d = aw_have_q;
    w_have_d  = w_have_q;
    awaddr_d  = awaddr_q;
    wdata_d   = wdata_q;
    wstrb_d   = wstrb_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    rvalid_d  = rvalid_q;
    rresp_d   = rresp_q;
    rdata_d   = rdata_q;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_have_d = 1'b1;
      awaddr_d  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_have_d = 1'b1;
      wdata_d  = s_axi_wdata;
      wstrb_d  = s_axi_wstrb;
    end
    wr_fire = aw_have_q && w_have_q && !bvalid_q;
    wr_addr = 8'(awaddr_q);
    wr_data = wdata_q;
    wr_strb = wstrb_q;
    if (wr_fire) begin
      aw_have_d = 1'b0;
      w_have_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = wr_known ? fep_pkg::RESP_OKAY : fep_pkg::RESP_SLVERR;
    end
    if (bvalid_q && s_axi_bready) bvalid_d = 1'b0;
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_d = 1'b1;
      rdata_d  = rd_val;
      rresp_d  = rd_known ? fep_pkg::RESP_OKAY : fep_pkg::RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      awaddr_q  <= '0;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= fep_pkg::RESP_OKAY;
      rvalid_q  <= 1'b0;
      rresp_q   <= fep_pkg::RESP_OKAY;
      rdata_q   <= 32'h0000_0000;
    end else begin
      aw_have_q <= aw_have_d;
      w_have_q  <= w_have_d;
      awaddr_q  <= awaddr_d;
      wdata_q   <= wdata_d;
      wstrb_q   <= wstrb_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      rvalid_q  <= rvalid_d;
      rresp_q   <= rresp_d;
      rdata_q   <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // core state

  localparam int IRQ_W      = fep_pkg::IRQ_W;
  localparam int EPS_HI     = fep_pkg::EPS_HI;
  localparam int EPS_LO     = fep_pkg::EPS_LO;
  localparam int FPS_HI     = fep_pkg::FPS_HI;
  localparam int FPS_LO     = fep_pkg::FPS_LO;
  localparam int IRQ_DONE   = fep_pkg::IRQ_DONE;
  localparam int IRQ_PVIOL  = fep_pkg::IRQ_PVIOL;
  localparam int IRQ_ACCERR = fep_pkg::IRQ_ACCERR;

  logic             load_q, load_d;
  logic [7:0]       prot_q, prot_d;
  logic [1:0]       sec_q, sec_d;
  logic [7:0]       cmd_q, cmd_d;
  logic [15:0]      addr_q, addr_d;
  logic [7:0]       data_q, data_d;
  logic [7:0]       cdiv_q, cdiv_d;
  logic             div_set_q, div_set_d;
  logic             cbef_q, cbef_d;
  logic             ccf_q, ccf_d;
  logic             pviol_q, pviol_d;
  logic             accerr_q, accerr_d;
  logic             blank_q, blank_d;
  logic             buf_q, buf_d;
  logic [7:0]       buf_cmd_q, buf_cmd_d;
  logic [15:0]      buf_addr_q, buf_addr_d;
  logic [7:0]       buf_data_q, buf_data_d;
  logic             exec_q, exec_d;
  logic [7:0]       exec_cmd_q, exec_cmd_d;
  logic [15:0]      exec_addr_q, exec_addr_d;
  logic             start_q, start_d;
  logic             abort_q, abort_d;
  logic [7:0]       acmd_q, acmd_d;
  logic [15:0]      aaddr_q, aaddr_d;
  logic [7:0]       adata_q, adata_d;
  logic [IRQ_W-1:0] irq_stat_q, irq_stat_d;
  logic [IRQ_W-1:0] irq_mask_q, irq_mask_d;

  logic [7:0]  stat_rd;
  logic [31:0] wr_word;
  logic        launch;
  logic        legal;
  logic        is_pe;
  logic        seq_bad;
  logic        hit;
  logic [7:0]  new_prot;
  logic [7:0]  ev;

  assign stat_rd = {cbef_q, ccf_q, pviol_q, accerr_q, 1'b0, blank_q, 2'b00};  // see [RULE18]

  assign arr_start           = start_q;
  assign arr_abort           = abort_q;
  assign arr_cmd             = acmd_q;
  assign arr_addr            = aaddr_q;
  assign arr_data            = adata_q;
  assign security_state_code = sec_q;
  assign irq                 = |(irq_stat_q & irq_mask_q);

  // register read mux and address decode
  always_comb begin
    rd_known = 1'b1;
    case (8'(s_axi_araddr))
      fep_pkg::OFF_PROT:     rd_val = {24'h000000, prot_q};  // see [RULE2]
      fep_pkg::OFF_STAT:     rd_val = {24'h000000, stat_rd};
      fep_pkg::OFF_CMD:      rd_val = {24'h000000, cmd_q};
      fep_pkg::OFF_ADDR:     rd_val = {16'h0000, addr_q};
      fep_pkg::OFF_DATA:     rd_val = {24'h000000, data_q};
      fep_pkg::OFF_CDIV:     rd_val = {24'h000000, cdiv_q};
      fep_pkg::OFF_SEC:      rd_val = {30'h00000000, sec_q};
      fep_pkg::OFF_IRQ_STAT: rd_val = {29'h00000000, irq_stat_q};
      fep_pkg::OFF_IRQ_MASK: rd_val = {29'h00000000, irq_mask_q};
      default: begin
        rd_val   = 32'h0000_0000;
        rd_known = 1'b0;
      end
    endcase
    case (wr_addr)
      fep_pkg::OFF_PROT, fep_pkg::OFF_STAT, fep_pkg::OFF_CMD, fep_pkg::OFF_ADDR,
      fep_pkg::OFF_DATA, fep_pkg::OFF_CDIV, fep_pkg::OFF_SEC, fep_pkg::OFF_IRQ_STAT,
      fep_pkg::OFF_IRQ_MASK: wr_known = 1'b1;
      default:               wr_known = 1'b0;
    endcase
  end

  always_comb begin
    load_d      = 1'b0;
    prot_d      = prot_q;
    sec_d       = sec_q;
    cmd_d       = cmd_q;
    addr_d      = addr_q;
    data_d      = data_q;
    cdiv_d      = cdiv_q;
    div_set_d   = div_set_q;
    cbef_d      = cbef_q;
    pviol_d     = pviol_q;
    accerr_d    = accerr_q;
    blank_d     = blank_q;
    buf_d       = buf_q;
    buf_cmd_d   = buf_cmd_q;
    buf_addr_d  = buf_addr_q;
    buf_data_d  = buf_data_q;
    exec_d      = exec_q;
    exec_cmd_d  = exec_cmd_q;
    exec_addr_d = exec_addr_q;
    start_d     = 1'b0;
    abort_d     = 1'b0;
    acmd_d      = acmd_q;
    aaddr_d     = aaddr_q;
    adata_d     = adata_q;
    irq_mask_d  = irq_mask_q;
    irq_stat_d  = irq_stat_q;
    wr_word     = lane_merge(32'h0000_0000, wr_data, wr_strb);
    launch      = 1'b0;
    new_prot    = wr_word[7:0];
    ev          = 8'h00;

    // software register writes
    if (wr_fire && wr_strb[0]) begin
      case (wr_addr)
        fep_pkg::OFF_PROT: begin
          if (new_prot[EPS_HI:EPS_LO] <= prot_q[EPS_HI:EPS_LO] &&
              fps_eff(new_prot[FPS_HI:FPS_LO]) <= fps_eff(prot_q[FPS_HI:FPS_LO]))
            prot_d = new_prot;  // see [RULE2]
        end
        fep_pkg::OFF_STAT: begin
          launch = wr_word[fep_pkg::STAT_CBEF];  // see [RULE7]
          if (wr_word[fep_pkg::STAT_PVIOL]) pviol_d = 1'b0;  // see [RULE10]
          if (wr_word[fep_pkg::STAT_ACCERR]) accerr_d = 1'b0;  // see [RULE12]
        end
        fep_pkg::OFF_CMD:  cmd_d = wr_word[7:0];
        fep_pkg::OFF_DATA: data_d = wr_word[7:0];
        fep_pkg::OFF_CDIV: begin
          cdiv_d    = wr_word[7:0];
          div_set_d = 1'b1;
        end
        fep_pkg::OFF_IRQ_STAT: irq_stat_d = irq_stat_q & ~wr_word[IRQ_W-1:0];
        fep_pkg::OFF_IRQ_MASK: irq_mask_d = wr_word[IRQ_W-1:0];
        default: ;
      endcase
    end
    if (wr_fire && wr_addr == fep_pkg::OFF_ADDR)
      addr_d = 16'(lane_merge({16'h0000, addr_q}, wr_data, wr_strb));

    if (debug_prot_we) prot_d = debug_prot_data;  // see [RULE16]
    if (load_q) begin
      prot_d = stored_protection_byte;  // see [RULE1]
      sec_d  = stored_security_code;
    end

    // array completion
    if (exec_q && arr_done) begin
      exec_d = 1'b0;
      if (exec_cmd_q == fep_pkg::CMD_BLANK && arr_blank_ok) begin
        blank_d = 1'b1;  // see [RULE13]
        if (exec_addr_q > fep_pkg::EE_REGION_END) sec_d = fep_pkg::SEC_UNSECURED;  // see [RULE17]
      end
      if (!buf_q) cbef_d = 1'b1;
    end

    // hand the buffered command to the array
    if (buf_q && !exec_q) begin
      start_d     = 1'b1;
      acmd_d      = buf_cmd_q;
      aaddr_d     = buf_addr_q;
      adata_d     = buf_data_q;
      exec_d      = 1'b1;
      exec_cmd_d  = buf_cmd_q;
      exec_addr_d = buf_addr_q;
      buf_d       = 1'b0;
      if (buf_cmd_q == fep_pkg::CMD_BURST) cbef_d = 1'b1;  // see [RULE7] [RULE8]
    end

    // command launch checks
    legal = (cmd_q == fep_pkg::CMD_BLANK) || (cmd_q == fep_pkg::CMD_BYTE) ||
            (cmd_q == fep_pkg::CMD_BURST) || (cmd_q == fep_pkg::CMD_SECT) ||
            (cmd_q == fep_pkg::CMD_MASS)  || (cmd_q == fep_pkg::CMD_ABORT);  // see [RULE14]
    is_pe = (cmd_q == fep_pkg::CMD_BYTE) || (cmd_q == fep_pkg::CMD_BURST) ||
            (cmd_q == fep_pkg::CMD_SECT) || (cmd_q == fep_pkg::CMD_MASS);
    seq_bad = (exec_q || buf_q) &&
              !(cmd_q == fep_pkg::CMD_BURST && exec_cmd_q == fep_pkg::CMD_BURST && !buf_q) &&
              !(cmd_q == fep_pkg::CMD_ABORT && exec_cmd_q == fep_pkg::CMD_SECT) ||
              (cmd_q == fep_pkg::CMD_ABORT && !exec_q);
    if (cmd_q == fep_pkg::CMD_MASS)
      hit = (prot_q[EPS_HI:EPS_LO] != fep_pkg::EPS_NONE) ||
            (prot_q[FPS_HI:FPS_LO] != fep_pkg::FPS_NONE);  // see [RULE4]
    else
      hit = is_pe && (ee_hit(addr_q, prot_q[EPS_HI:EPS_LO]) ||
                      fl_hit(addr_q, prot_q[FPS_HI:FPS_LO]));
    // abort is taken while a sector erase runs, although the buffer flag is low then
    if (launch && (cbef_q || (cmd_q == fep_pkg::CMD_ABORT && exec_q))) begin  // see [RULE14]
      if (!legal || (is_pe && !div_set_q) || stop_mode || seq_bad) begin
        accerr_d = 1'b1;  // see [RULE11] [RULE15]
      end else if (hit) begin
        pviol_d = 1'b1;  // see [RULE3]
      end else begin
        cbef_d  = 1'b0;  // see [RULE7]
        blank_d = 1'b0;  // see [RULE13]
        if (cmd_q == fep_pkg::CMD_ABORT && exec_q) begin
          abort_d = 1'b1;
        end else begin
          buf_d      = 1'b1;
          buf_cmd_d  = cmd_q;
          buf_addr_d = addr_q;
          buf_data_d = data_q;
        end
      end
    end

    // stop while busy kills the command
    if (stop_mode && (exec_q || buf_q)) begin
      accerr_d = 1'b1;  // see [RULE11]
      exec_d   = 1'b0;
      buf_d    = 1'b0;
      abort_d  = exec_q;
      cbef_d   = 1'b1;
    end

    ccf_d = cbef_d && !exec_d && !buf_d;  // see [RULE9]

    // sticky events, set wins over clear
    ev[IRQ_DONE]   = ccf_d && !ccf_q;
    ev[IRQ_PVIOL]  = pviol_d && !pviol_q;
    ev[IRQ_ACCERR] = accerr_d && !accerr_q;
    irq_stat_d = irq_stat_d | ev[IRQ_W-1:0];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      load_q      <= 1'b1;
      prot_q      <= fep_pkg::PROT_RESET;
      sec_q       <= fep_pkg::SEC_RESET;
      cmd_q       <= 8'h00;
      addr_q      <= 16'h0000;
      data_q      <= 8'h00;
      cdiv_q      <= fep_pkg::CDIV_RESET;
      div_set_q   <= 1'b0;
      cbef_q      <= 1'b1;
      ccf_q       <= 1'b1;
      pviol_q     <= 1'b0;
      accerr_q    <= 1'b0;
      blank_q     <= 1'b0;
      buf_q       <= 1'b0;
      buf_cmd_q   <= 8'h00;
      buf_addr_q  <= 16'h0000;
      buf_data_q  <= 8'h00;
      exec_q      <= 1'b0;
      exec_cmd_q  <= 8'h00;
      exec_addr_q <= 16'h0000;
      start_q     <= 1'b0;
      abort_q     <= 1'b0;
      acmd_q      <= 8'h00;
      aaddr_q     <= 16'h0000;
      adata_q     <= 8'h00;
      irq_stat_q  <= '0;
      irq_mask_q  <= '0;
    end else begin
      load_q      <= load_d;
      prot_q      <= prot_d;
      sec_q       <= sec_d;
      cmd_q       <= cmd_d;
      addr_q      <= addr_d;
      data_q      <= data_d;
      cdiv_q      <= cdiv_d;
      div_set_q   <= div_set_d;
      cbef_q      <= cbef_d;
      ccf_q       <= ccf_d;
      pviol_q     <= pviol_d;
      accerr_q    <= accerr_d;
      blank_q     <= blank_d;
      buf_q       <= buf_d;
      buf_cmd_q   <= buf_cmd_d;
      buf_addr_q  <= buf_addr_d;
      buf_data_q  <= buf_data_d;
      exec_q      <= exec_d;
      exec_cmd_q  <= exec_cmd_d;
      exec_addr_q <= exec_addr_d;
      start_q     <= start_d;
      abort_q     <= abort_d;
      acmd_q      <= acmd_d;
      aaddr_q     <= aaddr_d;
      adata_q     <= adata_d;
      irq_stat_q  <= irq_stat_d;
      irq_mask_q  <= irq_mask_d;
    end
  end

endmodule : fep_ctrl

// [tb/fep_ctrl_assertions.sv]
`timescale 1ns/10ps
module fep_ctrl_assertions (
  // clock and reset
  input wire logic       aclk,
  input wire logic       aresetn,
  // bus handshakes
  input wire logic       s_axi_awvalid,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_wvalid,
  input wire logic       s_axi_wready,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid,
  // array side
  input wire logic       arr_start,
  input wire logic       arr_abort,
  input wire logic [7:0] arr_cmd,
  input wire logic [1:0] security_state_code
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence both_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence read_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  write_answer_a: assert property (both_taken |-> ##2 s_axi_bvalid)
    else $error("write response not on time");
  read_answer_a: assert property (read_taken |=> s_axi_rvalid)
    else $error("read data not on time");
  write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
  start_pulse_a: assert property (arr_start |=> !arr_start)
    else $error("array start longer than one cycle");
  abort_pulse_a: assert property (arr_abort |=> !arr_abort)
    else $error("array abort longer than one cycle");
  legal_code_a: assert property (arr_start |-> arr_cmd inside {8'h05, 8'h20, 8'h25, 8'h40, 8'h41})
    else $error("array started with a refused code");
  sec_code_a: assert property ($changed(security_state_code) && $past(aresetn, 2)
    |-> security_state_code == fep_pkg::SEC_UNSECURED)
    else $error("security code changed to other than unsecured");
endmodule : fep_ctrl_assertions

bind fep_ctrl fep_ctrl_assertions u_fep_ctrl_assertions (.*);

// [tb/fep_ctrl_tb.sv]
`timescale 1ns/10ps
module fep_ctrl_tb;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_rready, debug_prot_we, stop_mode, arr_done, arr_blank_ok, irq;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        arr_start, arr_abort;
  logic [2:0]  s_axi_awprot, s_axi_arprot;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, stored_security_code, security_state_code, rr;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, stored_protection_byte, debug_prot_data;
  logic [7:0]  arr_cmd, arr_data, last_cmd;
  logic [15:0] arr_addr, last_addr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv;
  int          fail_count, n_tests, n_start, n_abort, s;
  logic [7:0]  codes [5] = '{8'h05, 8'h20, 8'h25, 8'h40, 8'h41};
  logic [7:0]  pc [4] = '{8'h20, 8'h40, 8'h41, 8'h20};
  logic [15:0] pa [4] = '{16'hF400, 16'h17E0, 16'h0100, 16'hFFFF};

  fep_ctrl u_fep_ctrl (.*);

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // count array pulses mid-cycle, away from the launching edge
  always @(negedge aclk) begin
    if (arr_start === 1'b1) n_start++;
    if (arr_start === 1'b1) last_cmd = arr_cmd;
    if (arr_start === 1'b1) last_addr = arr_addr;
    if (arr_abort === 1'b1) n_abort++;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    if (fail_count == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      fail_count++;
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ha, hw, hb;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    hb = 1'b0;
    while (!hb) begin
      @(negedge aclk);
      ha = s_axi_awvalid && s_axi_awready;
      hw = s_axi_wvalid && s_axi_wready;
      hb = s_axi_bvalid;
      @(posedge aclk);
      if (ha) s_axi_awvalid <= 1'b0;
      if (hw) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ha, hr;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    hr = 1'b0;
    while (!hr) begin
      @(negedge aclk);
      ha = s_axi_arvalid && s_axi_arready;
      hr = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ha) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
  endtask : rd

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk(d, exp);
  endtask : rchk

  task automatic cmd(input logic [7:0] c, input logic [15:0] ad);
    wr(fep_pkg::OFF_CMD, {24'h0, c});
    wr(fep_pkg::OFF_ADDR, {16'h0, ad});
    wr(fep_pkg::OFF_STAT, 32'h80);
  endtask : cmd

  task automatic done_pulse();
    @(posedge aclk);
    arr_done <= 1'b1;
    @(posedge aclk);
    arr_done <= 1'b0;
  endtask : done_pulse

  ////////////////////////////////////////////////////////////////////////
  initial begin
    #200000;
    fail_count++;
    wrap_up();
  end

  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {debug_prot_we, stop_mode, arr_done, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awprot, s_axi_arprot, debug_prot_data, stored_security_code} = '0;
    s_axi_wstrb = 4'hF;
    arr_blank_ok = 1'b1;
    stored_protection_byte = 8'hBE;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rchk(fep_pkg::OFF_PROT, 32'hBE);
    chk(security_state_code, 32'h0);
    wr(fep_pkg::OFF_STAT, 32'h0F);
    rchk(fep_pkg::OFF_STAT, 32'hC0);
    wr(fep_pkg::OFF_PROT, 32'hFF);
    rchk(fep_pkg::OFF_PROT, 32'hBE);
    wr(fep_pkg::OFF_PROT, 32'h7D);
    rchk(fep_pkg::OFF_PROT, 32'h7D);
    wr(fep_pkg::OFF_IRQ_MASK, 32'h7);
    cmd(fep_pkg::CMD_BYTE, 16'h1000);
    rchk(fep_pkg::OFF_STAT, 32'hD0);
    chk(irq, 32'h1);
    wr(fep_pkg::OFF_STAT, 32'h00);
    rchk(fep_pkg::OFF_STAT, 32'hD0);
    wr(fep_pkg::OFF_STAT, 32'h10);
    wr(fep_pkg::OFF_CDIV, 32'h1);
    cmd(8'h30, 16'h1000);
    rchk(fep_pkg::OFF_STAT, 32'hD0);
    wr(fep_pkg::OFF_STAT, 32'h10);
    for (int i = 0; i < 4; i++) begin
      cmd(pc[i], pa[i]);
      rchk(fep_pkg::OFF_STAT, 32'hE0);
      wr(fep_pkg::OFF_STAT, 32'h00);
      rchk(fep_pkg::OFF_STAT, 32'hE0);
      wr(fep_pkg::OFF_STAT, 32'h20);
    end
    s = n_start;
    cmd(fep_pkg::CMD_BYTE, 16'hF3FF);
    done_pulse();
    cmd(fep_pkg::CMD_BYTE, 16'h17DF);
    done_pulse();
    chk(n_start, s + 2);
    @(posedge aclk);
    debug_prot_data <= 8'hFF;
    debug_prot_we <= 1'b1;
    @(posedge aclk);
    debug_prot_we <= 1'b0;
    rchk(fep_pkg::OFF_PROT, 32'hFF);
    arr_blank_ok <= 1'b0;
    cmd(fep_pkg::CMD_BLANK, 16'h8000);
    done_pulse();
    rchk(fep_pkg::OFF_STAT, 32'hC0);
    chk(security_state_code, 32'h0);
    arr_blank_ok <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      s = n_start;
      cmd(codes[i], 16'h8000);
      rchk(fep_pkg::OFF_STAT, codes[i] == 8'h25 ? 32'h80 : 32'h00);
      chk(n_start, s + 1);
      chk(last_cmd, codes[i]);
      chk(last_addr, 32'h8000);
      done_pulse();
      rchk(fep_pkg::OFF_STAT, codes[i] == 8'h05 ? 32'hC4 : 32'hC0);
    end
    chk(security_state_code, fep_pkg::SEC_UNSECURED);
    cmd(fep_pkg::CMD_SECT, 16'h8000);
    s = n_abort;
    cmd(fep_pkg::CMD_ABORT, 16'h8000);
    chk(n_abort, s + 1);
    done_pulse();
    cmd(fep_pkg::CMD_BYTE, 16'h8000);
    s = n_abort;
    stop_mode <= 1'b1;
    rchk(fep_pkg::OFF_STAT, 32'hD0);
    stop_mode <= 1'b0;
    chk(n_abort, s + 1);
    rchk(fep_pkg::OFF_IRQ_STAT, 32'h7);
    wr(fep_pkg::OFF_IRQ_MASK, 32'h0);
    chk(irq, 32'h0);
    wr(fep_pkg::OFF_IRQ_MASK, 32'h7);
    wr(fep_pkg::OFF_IRQ_STAT, 32'h7);
    rchk(fep_pkg::OFF_IRQ_STAT, 32'h0);
    chk(irq, 32'h0);
    rd(8'h40, rv, rr);
    chk(rr, fep_pkg::RESP_SLVERR);
    wrap_up();
  end
endmodule : fep_ctrl_tb
